/* File: rtl/ci_alarm_pkg.sv */
// types shared by the framer control and ci alarm bank
// assumes the constants header is included by the design file
package ci_alarm_pkg;
  typedef enum logic [3:0]
  {
    G_OFF = 4'h1,
    G_AIS = 4'h2,
    G_MSG = 4'h4,
    G_SIG = 4'h8
  } gen_state_t;
  typedef struct packed
  {
    logic status_clear_style_select;
    logic enable_autoclear_on_read;
    logic framer_irq_master_enable;
  } int_ctrl_t;
  typedef struct packed
  {
    logic [1:0] ci_alarm_transmit_select;
    logic [1:0] ci_alarm_detect_select;
  } ci_ctrl_t;
endpackage

/* File: rtl/ci_alarm_regs.svh */
// offsets, field positions, reset values, patterns and timing for the ci alarm bank
// assumes a byte-addressed axi4-lite window of 8 address bits
`ifndef CI_ALARM_REGS_SVH
`define CI_ALARM_REGS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define OFF_INT_CTRL 8'h00
`define OFF_LINK_SEL 8'h04
`define OFF_CI_CTRL 8'h08
`define OFF_STATUS 8'h0C
`define OFF_CLEAR 8'h10
`define OFF_ENABLE 8'h14
// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define INT_CTRL_W 3
`define LINK_SEL_W 2
`define CI_CTRL_W 4
`define STAT_W 2
`define STAT_AIS_BIT 0
`define STAT_RAI_BIT 1
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define INT_CTRL_RST 3'h0
`define LINK_SEL_RST 2'h0
`define CI_CTRL_RST 4'h0
`define STAT_RST 2'h0
`define CI_SEL_AIS 2'h1
`define CI_SEL_RAI 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// patterns (sent lsb first) and timing
// ----------------------------------------------------------------
`define AIS_SIG_PAT 16'h7CFF
`define RAI_MSG_PAT 16'h00FF
`define RAI_SIG_PAT 16'h3EFF
`define AIS_LAST_POS 9'h181
`define RAI_MSG_MS 990
`define RAI_SIG_MS 90
`define CLK_KHZ 100000
`endif

/* File: rtl/framer_control_and_ci_alarm_regs.sv */
// framer interrupt control, link controller select and ci alarm generation/detection
// assumes line bit strobes and esf indication come from framer logic on aclk
`timescale 1ns/10ps
`include "ci_alarm_regs.svh"

// Functional notes
// R01 - interrupt control bit 2 picks clear-on-read (0) or write-to-clear (1) for status bits.
// R02 - with enable auto-clear at 0, enable bits keep their value when status is read.
// R03 - with enable auto-clear at 1, reading a status bit clears its matching enable bit.
// R04 - interrupt control bit 0 gates every framer interrupt: 0 blocks, 1 permits.
// R05 - controller select 00 or 11 picks controller one, 01 picks two, 10 picks three.
// R06 - alarm transmit field [3:2]: 00/11 off, 01 unframed indication alarm, 10 remote alarm.
// R07 - alarm generation only acts while the framer runs extended superframe.
// R08 - the indication alarm is all ones with a 16-bit signature, lsb first, every 386 bits.
// R09 - the remote alarm repeats every 1.08 s: 0.99 s of message then 90 ms of signature.
// R10 - remote alarm message is 00000000 11111111, its signature 00111110 11111111, lsb first.
// R11 - alarm detect field [1:0]: 00/11 off, 01 indication alarm, 10 remote alarm, esf only.
// R12 - all fields reset to zero: interrupts, generation and detection off, controller one.
// R13 - reserved bits read as zero and ignore writes.
// R14 - a recognised enabled alarm sets a status flag reported by the interrupt logic.
module framer_control_and_ci_alarm_regs #(
  parameter int RAI_MSG_CYC = `RAI_MSG_MS * `CLK_KHZ,
  parameter int RAI_SIG_CYC = `RAI_SIG_MS * `CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic esf_mode,
  input wire logic tx_bit_en,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  output logic tx_ci_bit,
  output logic tx_ci_active,
  output logic [2:0] hdlc_ctrl_onehot,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [7:0] waddr_r, waddr_nxt, wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  ci_alarm_pkg::int_ctrl_t int_r, int_nxt;
  logic [`LINK_SEL_W-1:0] lsel_r, lsel_nxt;
  ci_alarm_pkg::ci_ctrl_t ci_r, ci_nxt;
  logic [`STAT_W-1:0] stat_r, stat_nxt, en_r, en_nxt, hit_r, hit_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [15:0] sh_r, sh_nxt;
  ci_alarm_pkg::gen_state_t gen_r, gen_nxt;
  logic [26:0] tmr_r, tmr_nxt;
  logic [8:0] pos_r, pos_nxt;
  logic bit_r, bit_nxt, act_r, act_nxt;
  logic wr_go, rd_go, rd_status;
  logic [1:0] tx_mode;
  // patterns held as vectors so one bit can be picked by index
  localparam logic [15:0] AIS_PAT = `AIS_SIG_PAT;
  localparam logic [15:0] RAI_MSG_PAT_V = `RAI_MSG_PAT;
  localparam logic [15:0] RAI_SIG_PAT_V = `RAI_SIG_PAT;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFF_INT_CTRL) || (a == `OFF_LINK_SEL) || (a == `OFF_CI_CTRL) ||
                (a == `OFF_STATUS) || (a == `OFF_CLEAR) || (a == `OFF_ENABLE);
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign awready = !aw_full_r && !bvalid_r;
  assign wready = !w_full_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign rd_go = arvalid && arready;
  assign rd_status = rd_go && (araddr == `OFF_STATUS);
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_comb
  begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    waddr_nxt = waddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready)
    begin
      aw_full_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready)
    begin
      w_full_nxt = 1'b1;
      wbyte_nxt = wdata[7:0];
      wlane_nxt = wstrb[0];
    end
    if (wr_go)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_mapped(waddr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (bvalid_r && bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      // unused upper bits read as zero
      unique case (araddr) // see R13
        `OFF_INT_CTRL: rdata_nxt = {29'h0000_0000, int_r};
        `OFF_LINK_SEL: rdata_nxt = {30'h0000_0000, lsel_r};
        `OFF_CI_CTRL: rdata_nxt = {28'h000_0000, ci_r};
        `OFF_STATUS: rdata_nxt = {30'h0000_0000, stat_r};
        `OFF_ENABLE: rdata_nxt = {30'h0000_0000, en_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control, status and enable registers
  // ----------------------------------------------------------------
  always_comb
  begin
    int_nxt = int_r;
    lsel_nxt = lsel_r;
    ci_nxt = ci_r;
    en_nxt = en_r;
    stat_nxt = stat_r;
    if (wr_go && wlane_r)
    begin
      unique case (waddr_r)
        `OFF_INT_CTRL: int_nxt = ci_alarm_pkg::int_ctrl_t'(wbyte_r[`INT_CTRL_W-1:0]); // see R13
        `OFF_LINK_SEL: lsel_nxt = wbyte_r[`LINK_SEL_W-1:0];
        `OFF_CI_CTRL: ci_nxt = ci_alarm_pkg::ci_ctrl_t'(wbyte_r[`CI_CTRL_W-1:0]);
        `OFF_ENABLE: en_nxt = wbyte_r[`STAT_W-1:0];
        `OFF_CLEAR:
        begin
          if (int_r.status_clear_style_select)
          begin
            stat_nxt = stat_nxt & ~wbyte_r[`STAT_W-1:0]; // see R01
          end
        end
        default: ;
      endcase
    end
    if (rd_status)
    begin
      if (!int_r.status_clear_style_select)
      begin
        stat_nxt = stat_nxt & ~stat_r; // see R01
      end
      if (int_r.enable_autoclear_on_read)
      begin
        en_nxt = en_nxt & ~stat_r; // see R03
      end
    end
    // a new event in the clearing cycle survives
    stat_nxt = stat_nxt | hit_r; // see R14
  end

  // r05 decode kept in a flop so the select lines never glitch
  always_comb
  begin
    unique case (lsel_r) // see R05
      2'h1: sel_nxt = 3'h2;
      2'h2: sel_nxt = 3'h4;
      default: sel_nxt = 3'h1;
    endcase
  end

  assign irq = int_r.framer_irq_master_enable && |(stat_r & en_r); // see R04
  assign hdlc_ctrl_onehot = sel_r;

  // ----------------------------------------------------------------
  // alarm detection
  // ----------------------------------------------------------------
  // single signature match, no persistence filter; software qualifies
  always_comb
  begin
    sh_nxt = sh_r;
    hit_nxt = '0;
    if (rx_bit_en)
    begin
      sh_nxt = {rx_bit, sh_r[15:1]};
      if (esf_mode) // see R11
      begin
        hit_nxt[`STAT_AIS_BIT] = (ci_r.ci_alarm_detect_select == `CI_SEL_AIS) &&
                                 (sh_nxt == `AIS_SIG_PAT);
        hit_nxt[`STAT_RAI_BIT] = (ci_r.ci_alarm_detect_select == `CI_SEL_RAI) &&
                                 (sh_nxt == `RAI_SIG_PAT);
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm generation
  // ----------------------------------------------------------------
  assign tx_mode = esf_mode ? ci_r.ci_alarm_transmit_select : 2'h0; // see R07

  always_comb
  begin
    gen_nxt = gen_r;
    tmr_nxt = tmr_r;
    pos_nxt = pos_r;
    bit_nxt = bit_r;
    unique case (gen_r) // see R06
      ci_alarm_pkg::G_OFF:
      begin
        pos_nxt = 9'h000;
        tmr_nxt = 27'h000_0000;
        bit_nxt = 1'b1;
        if (tx_mode == `CI_SEL_AIS)
        begin
          gen_nxt = ci_alarm_pkg::G_AIS;
        end
        else if (tx_mode == `CI_SEL_RAI)
        begin
          gen_nxt = ci_alarm_pkg::G_MSG;
        end
      end
      ci_alarm_pkg::G_AIS:
      begin
        if (tx_mode != `CI_SEL_AIS)
        begin
          gen_nxt = ci_alarm_pkg::G_OFF;
        end
        else if (tx_bit_en)
        begin
          bit_nxt = (pos_r < 9'h010) ? AIS_PAT[pos_r[3:0]] : 1'b1; // see R08
          pos_nxt = (pos_r == `AIS_LAST_POS) ? 9'h000 : pos_r + 9'h001;
        end
      end
      ci_alarm_pkg::G_MSG,
      ci_alarm_pkg::G_SIG:
      begin
        if (tx_mode != `CI_SEL_RAI)
        begin
          gen_nxt = ci_alarm_pkg::G_OFF;
        end
        else
        begin
          tmr_nxt = tmr_r + 27'h000_0001;
          if (gen_r == ci_alarm_pkg::G_MSG && tmr_r == 27'(RAI_MSG_CYC - 1)) // see R09
          begin
            gen_nxt = ci_alarm_pkg::G_SIG;
            tmr_nxt = 27'h000_0000;
          end
          if (gen_r == ci_alarm_pkg::G_SIG && tmr_r == 27'(RAI_SIG_CYC - 1))
          begin
            gen_nxt = ci_alarm_pkg::G_MSG;
            tmr_nxt = 27'h000_0000;
          end
          if (tx_bit_en)
          begin
            bit_nxt = (gen_r == ci_alarm_pkg::G_MSG) ? RAI_MSG_PAT_V[pos_r[3:0]]
                                                     : RAI_SIG_PAT_V[pos_r[3:0]]; // see R10
            pos_nxt = {5'h00, pos_r[3:0] + 4'h1};
          end
        end
      end
      default: gen_nxt = ci_alarm_pkg::G_OFF;
    endcase
    act_nxt = (gen_nxt != ci_alarm_pkg::G_OFF);
  end

  assign tx_ci_bit = bit_r;
  assign tx_ci_active = act_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      int_r <= `INT_CTRL_RST; // see R12
      lsel_r <= `LINK_SEL_RST;
      ci_r <= `CI_CTRL_RST;
      stat_r <= `STAT_RST;
      en_r <= `STAT_RST;
      hit_r <= `STAT_RST;
      sel_r <= 3'h1;
      sh_r <= 16'h0000;
      gen_r <= ci_alarm_pkg::G_OFF;
      tmr_r <= 27'h000_0000;
      pos_r <= 9'h000;
      bit_r <= 1'b1;
      act_r <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      waddr_r <= waddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      int_r <= int_nxt;
      lsel_r <= lsel_nxt;
      ci_r <= ci_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      hit_r <= hit_nxt;
      sel_r <= sel_nxt;
      sh_r <= sh_nxt;
      gen_r <= gen_nxt;
      tmr_r <= tmr_nxt;
      pos_r <= pos_nxt;
      bit_r <= bit_nxt;
      act_r <= act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_msg_end;
    gen_r == ci_alarm_pkg::G_MSG && tmr_r == 27'(RAI_MSG_CYC - 1) && tx_mode == `CI_SEL_RAI;
  endsequence
  sequence s_sig_start;
    gen_r == ci_alarm_pkg::G_SIG && tmr_r == 27'h000_0000;
  endsequence

  a_rur_clear: assert property (rd_status && !int_r.status_clear_style_select && hit_r == 2'h0
    |=> (stat_r & $past(stat_r)) == 2'h0) else $error("status not cleared on read"); // see R01
  a_wc_hold: assert property (rd_status && int_r.status_clear_style_select && !wr_go
    |=> stat_r == ($past(stat_r) | $past(hit_r))) else $error("status lost on read"); // see R01
  a_en_keep: assert property (rd_status && !int_r.enable_autoclear_on_read && !wr_go
    |=> en_r == $past(en_r)) else $error("enable changed by read"); // see R02
  a_en_auto: assert property (rd_status && int_r.enable_autoclear_on_read
    |=> (en_r & $past(stat_r)) == 2'h0) else $error("enable not auto-cleared"); // see R03
  a_irq_master: assert property (irq |-> int_r.framer_irq_master_enable && (stat_r & en_r) != 2'h0)
    else $error("irq without enabled cause"); // see R04
  a_sel_decode: assert property (##1 hdlc_ctrl_onehot ==
    (($past(lsel_r) == 2'h1) ? 3'h2 : ($past(lsel_r) == 2'h2) ? 3'h4 : 3'h1))
    else $error("controller select decode wrong"); // see R05
  a_esf_gate: assert property (!esf_mode |=> !tx_ci_active) else $error("alarm sent outside esf"); // see R07
  a_ais_ones: assert property (gen_r == ci_alarm_pkg::G_AIS && tx_mode == `CI_SEL_AIS && tx_bit_en &&
    pos_r >= 9'h010 |=> tx_ci_bit) else $error("ais fill not ones"); // see R08
  a_rai_seq: assert property (s_msg_end |=> s_sig_start) else $error("rai message length wrong"); // see R09
  a_reset_zero: assert property (!$past(aresetn) |-> int_r == 3'h0 && ci_r == 4'h0 && lsel_r == 2'h0)
    else $error("control not zero after reset"); // see R12
  a_hit_sets: assert property (hit_r != 2'h0 |=> (stat_r & $past(hit_r)) == $past(hit_r))
    else $error("detected alarm not flagged"); // see R14
endmodule

/* File: sim/tb.sv */
// self-checking bench for the framer control and ci alarm register bank
// assumes the design file and its constants header are compiled alongside
`timescale 1ns/10ps
`include "ci_alarm_regs.svh"

module tb;
  // short generator phases keep the run brief; the rai generation expectations derive from them
  localparam int MSG_CYC = 200;
  localparam int SIG_CYC = 20;
  localparam int PER = MSG_CYC + SIG_CYC;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, w;
  logic [3:0] wstrb;
  logic esf_mode, tx_bit_en, rx_bit_en, rx_bit;
  logic awready, wready, bvalid, arready, rvalid, tx_ci_bit, tx_ci_active, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] hdlc_ctrl_onehot;
  logic [31:0] rd_q[$];
  logic [1:0] rr_q[$];
  logic [15:0] pa, pm, ps;
  logic [7:0] offs[3];
  logic [31:0] msk[3];
  logic [2:0] oh[4];
  logic e, m, s, ok;
  int fails, compares, cyc, sm, ph;
  integer seed;

  framer_control_and_ci_alarm_regs #(.RAI_MSG_CYC(MSG_CYC), .RAI_SIG_CYC(SIG_CYC)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .esf_mode(esf_mode),
    .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .tx_ci_bit(tx_ci_bit),
    .tx_ci_active(tx_ci_active), .hdlc_ctrl_onehot(hdlc_ctrl_onehot), .irq(irq)
  );

  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, wd;
    aw = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && wd))
    begin
      @(posedge aclk);
      if (!aw && awready === 1'b1)
      begin
        aw = 1;
        awvalid <= 0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", r, bresp);
  endtask

  // the watcher below compares the data against the queued note
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    rd_q.push_back(ex);
    // mapped words are the six aligned offsets below 0x18
    rr_q.push_back((a < 8'h18 && a[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask

  task automatic feed(input logic [15:0] p);
    for (int i = 0; i < 16; i++)
    begin
      rx_bit <= p[i];
      rx_bit_en <= 1;
      @(posedge aclk);
    end
    rx_bit_en <= 0;
    repeat (3) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0)
    begin
      chk("rdata", rd_q.pop_front(), rdata);
      if (rr_q.size() > 0)
        chk("rresp", rr_q.pop_front(), rresp);
    end
    if (cyc > 20000)
    begin
      fails++;
      $display("BAD timeout expected %0d seen %0d", 20000, cyc);
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'hb550;
    pa = `AIS_SIG_PAT;
    pm = `RAI_MSG_PAT;
    ps = `RAI_SIG_PAT;
    offs = '{`OFF_INT_CTRL, `OFF_LINK_SEL, `OFF_CI_CTRL};
    msk = '{32'h7, 32'h3, 32'hF};
    oh = '{3'b001, 3'b010, 3'b100, 3'b001};
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {esf_mode, tx_bit_en, rx_bit_en, rx_bit} = '0;
    wstrb = 4'hF;
    bready = 1;
    rready = 1;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++)
      rd(offs[i], 0);
    chk("onehot", 3'b001, hdlc_ctrl_onehot);
    chk("tx bit", 1, tx_ci_bit);
    chk("active", 0, tx_ci_active);
    chk("irq", 0, irq);
    done("reset");
    for (int i = 0; i < 3; i++)
    begin
      w = $random(seed);
      wr(offs[i], w, `RESP_OKAY);
      rd(offs[i], w & msk[i]);
      wr(offs[i], 0, `RESP_OKAY);
    end
    wr(8'h18, w, `RESP_SLVERR);
    rd(8'h18, 0);
    done("reserved");
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFF_LINK_SEL, c, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("onehot", oh[c], hdlc_ctrl_onehot);
    end
    done("link select");
    wr(`OFF_CI_CTRL, 32'h4, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("active", 0, tx_ci_active);
    esf_mode <= 1;
    wr(`OFF_CI_CTRL, 32'hC, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("active", 0, tx_ci_active);
    wr(`OFF_CI_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFF_CI_CTRL, 32'h4, `RESP_OKAY);
    do @(posedge aclk); while (tx_ci_active !== 1'b1);
    for (int k = 0; k < 772; k++)
    begin
      tx_bit_en <= 1;
      @(posedge aclk);
      tx_bit_en <= 0;
      @(posedge aclk);
      e = (k % 386 < 16) ? pa[k % 386] : 1'b1;
      chk("ais bit", e, tx_ci_bit);
    end
    done("ais generation");
    wr(`OFF_CI_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFF_CI_CTRL, 32'h8, `RESP_OKAY);
    do @(posedge aclk); while (tx_ci_active !== 1'b1);
    sm = 0;
    tx_bit_en <= 1;
    @(posedge aclk);
    for (int k = 0; k < 2 * PER; k++)
    begin
      @(posedge aclk);
      m = pm[k % 16];
      s = ps[k % 16];
      ph = k % PER;
      ok = (tx_ci_bit === m) || (tx_ci_bit === s);
      if (m !== s && tx_ci_bit === s)
      begin
        sm++;
        ok = ok && ph >= MSG_CYC - 5;
      end
      else if (m !== s)
        ok = ok && !(ph > MSG_CYC && ph < PER - 4);
      chk("rai bit", 1, ok);
    end
    tx_bit_en <= 0;
    chk("rai sig seen", 1, sm > 0);
    wr(`OFF_CI_CTRL, 32'h0, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("idle bit", 1, tx_ci_bit);
    done("rai generation");
    wr(`OFF_INT_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFF_ENABLE, 32'h3, `RESP_OKAY);
    feed(16'($random(seed)));
    feed(pa);
    rd(`OFF_STATUS, 0);
    esf_mode <= 0;
    wr(`OFF_CI_CTRL, 32'h1, `RESP_OKAY);
    feed(pa);
    rd(`OFF_STATUS, 0);
    esf_mode <= 1;
    wr(`OFF_CI_CTRL, 32'h3, `RESP_OKAY);
    feed(pa);
    rd(`OFF_STATUS, 0);
    wr(`OFF_CI_CTRL, 32'h1, `RESP_OKAY);
    feed(pa);
    chk("irq", 1, irq);
    wr(`OFF_INT_CTRL, 32'h0, `RESP_OKAY);
    chk("irq", 0, irq);
    wr(`OFF_INT_CTRL, 32'h1, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h1);
    rd(`OFF_STATUS, 0);
    rd(`OFF_ENABLE, 32'h3);
    chk("irq", 0, irq);
    wr(`OFF_CI_CTRL, 32'h2, `RESP_OKAY);
    wr(`OFF_INT_CTRL, 32'h3, `RESP_OKAY);
    feed(ps);
    rd(`OFF_STATUS, 32'h2);
    rd(`OFF_ENABLE, 32'h1);
    wr(`OFF_INT_CTRL, 32'h5, `RESP_OKAY);
    wr(`OFF_ENABLE, 32'h3, `RESP_OKAY);
    feed(ps);
    rd(`OFF_STATUS, 32'h2);
    rd(`OFF_STATUS, 32'h2);
    chk("irq", 1, irq);
    wr(`OFF_CLEAR, 32'h2, `RESP_OKAY);
    rd(`OFF_STATUS, 0);
    chk("irq", 0, irq);
    done("detect and interrupts");
    repeat (2) @(posedge aclk);
    end_sim;
  end
endmodule
